// *** design/hcc_pkg.sv ***
// Purpose: Shared constants and carrier types for the hall commutation controller
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Hall code is {A,B,C}; phase one-hot uses bit 2 = A, bit 1 = B, bit 0 = C
package hcc_pkg;

  // Clock rate
  localparam int CLK_MHZ = 200;

  // Register byte offsets
  localparam logic [7:0] HCC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HCC_DUTY_OFS   = 8'h04;
  localparam logic [7:0] HCC_PERIOD_OFS = 8'h08;
  localparam logic [7:0] HCC_DEAD_OFS   = 8'h0C;
  localparam logic [7:0] HCC_UVTHR_OFS  = 8'h10;
  localparam logic [7:0] HCC_OCLIM_OFS  = 8'h14;
  localparam logic [7:0] HCC_STS_OFS    = 8'h18;
  localparam logic [7:0] HCC_MASK_OFS   = 8'h1C;
  localparam logic [7:0] HCC_SPEED_OFS  = 8'h20;
  localparam logic [7:0] HCC_LIVE_OFS   = 8'h24;

  // Timing figures and derived cycle counts
  localparam int DEAD_NS     = 100;
  localparam int DEAD_CYC    = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int SPD_WIN_US  = 10000;
  localparam int SPD_WIN_CYC = SPD_WIN_US * CLK_MHZ;

  // Values after reset
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [15:0] DUTY_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h03E8;
  localparam logic [15:0] DEAD_RST   = 16'(DEAD_CYC);
  localparam logic [11:0] UVTHR_RST  = 12'h800;
  localparam logic [11:0] OCLIM_RST  = 12'hC00;

  // Status and mask bit positions
  localparam int ST_HALL  = 0;
  localparam int ST_UV    = 1;
  localparam int ST_OCLIM = 2;
  localparam int ST_OCTRP = 3;
  localparam int ST_BRAKE = 4;
  localparam int ST_STEP  = 5;
  localparam int ST_W     = 6;

  typedef struct packed {
    logic brake_pol;
    logic sync_rect;
    logic reverse;
    logic enable;
  } hcc_ctrl_t;

  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } hcc_gate_t;

endpackage

// *** design/hcc_sync.sv ***
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module hcc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Pins and synchronised copy
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages; no logic taps the first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule

// *** design/hcc_pwm.sv ***
// Purpose: Edge-aligned PWM with complementary output and dead time
// Assumes: duty >= period gives a full-on output
// Notes:   One shared counter keeps every gate on a common period start
`timescale 1ns/1ps
module hcc_pwm #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Settings
  input  wire logic [W-1:0] period,
  input  wire logic [W-1:0] duty,
  input  wire logic [W-1:0] dead,
  input  wire logic         restart,
  // Outputs
  output logic              pwm_h,
  output logic              pwm_l
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic [W-1:0] dt_ff;
  logic [W-1:0] nxt_dt;
  logic         raw_ff;
  logic         nxt_raw;

  // Period counter, restart realigns all outputs
  always_comb begin
    nxt_cnt = cnt_ff + 1'b1;
    if (restart || nxt_cnt >= period) begin
      nxt_cnt = '0;
    end
    nxt_raw = (nxt_cnt < duty);
    nxt_dt  = (nxt_raw != raw_ff) ? '0 : ((dt_ff == '1) ? dt_ff : dt_ff + 1'b1);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      raw_ff <= 1'b0;
      dt_ff  <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      raw_ff <= nxt_raw;
      dt_ff  <= nxt_dt;
    end
  end

  // Both sides wait out the dead time after any change
  assign pwm_h = raw_ff && (dt_ff >= dead);
  assign pwm_l = !raw_ff && (dt_ff >= dead);
endmodule

// *** design/hcc_top.sv ***
// Purpose: Six-step hall commutation controller with protection and AHB-Lite registers
// Assumes: Single 200 MHz clock; ADC samples arrive on clk already
// Notes:   Modulated switch is the high side; the low side is held full on
// Behaviour
// - Three hall inputs form one three-bit rotor position code.
// - Only six codes valid; 000 and 111 flag a sensor-line fault.
// - Every rising or falling hall change re-evaluates the commutation step.
// - Forward table maps each code to one high and one low phase.
// - Reverse uses the same phases with high and low swapped.
// - Each step drives one high and one low switch on different phases.
// - Without synchronous rectification the modulated switch's complement stays off.
// - One active switch carries speed PWM, the other full duty.
// - Loading a new duty restarts all PWM periods together.
// - Optional synchronous rectification drives the complement with dead time.
// - Battery sample below programmable threshold enters undervoltage protection.
// - Current sample above programmable limit declares overcurrent.
// - External comparator trip input also declares overcurrent.
// - Brake polarity is selectable: active high or active low.
// - Speed is hall transitions counted over a fixed time window.
// - Larger speed duty gives higher motor speed.
// - Active brake level forces a fault; only its status bit is set on input edges.
`timescale 1ns/1ps
module hcc_top
  import hcc_pkg::*;
#(
  parameter int PW      = 16,
  parameter int AW      = 12,
  parameter int SPD_WIN = hcc_pkg::SPD_WIN_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Sensor and protection pins
  input  wire logic [2:0]        hall_pin,
  input  wire logic              brake_pin,
  input  wire logic              oc_trip_pin,
  // ADC samples, same clock
  input  wire logic [AW-1:0]     adc_vbat,
  input  wire logic [AW-1:0]     adc_ibus,
  // Bridge gates and interrupt
  output hcc_pkg::hcc_gate_t     gate,
  output logic                   irq
);
  import hcc_pkg::*;

  localparam int SW = $clog2(SPD_WIN + 1);

  logic [2:0]      hall_s;
  logic            brake_s;
  logic            trip_s;
  logic            pwm_h;
  logic            pwm_l;
  hcc_ctrl_t       ctrl_ff, nxt_ctrl;
  logic [PW-1:0]   duty_ff, nxt_duty;
  logic [PW-1:0]   period_ff, nxt_period;
  logic [PW-1:0]   dead_ff, nxt_dead;
  logic [AW-1:0]   uvthr_ff, nxt_uvthr;
  logic [AW-1:0]   oclim_ff, nxt_oclim;
  logic [ST_W-1:0] sts_ff, nxt_sts, sts_set;
  logic [ST_W-1:0] mask_ff, nxt_mask;
  logic [2:0]      hall_prev_ff;
  logic            brake_prev_ff;
  hcc_gate_t       comm_ff, nxt_comm;
  hcc_gate_t       gate_ff, nxt_gate;
  logic [SW-1:0]   win_ff, nxt_win;
  logic [15:0]     edges_ff, nxt_edges;
  logic [15:0]     speed_ff, nxt_speed;
  logic            wr_ff, nxt_wr;
  logic [7:0]      wa_ff, nxt_wa;
  logic [31:0]     rd_ff, nxt_rd;
  logic            hall_edge, hall_bad, uv, oclim, brake_on, fault, duty_ld, acc;

  // Pin inputs cross into clk first
  hcc_sync #(.W(5)) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     ({hall_pin, brake_pin, oc_trip_pin}),
    .dout    ({hall_s, brake_s, trip_s})
  );

  // Shared PWM for the speed switch
  hcc_pwm #(.W(PW)) u_pwm (
    .clk     (clk),
    .sys_rst (sys_rst),
    .period  (period_ff),
    .duty    (duty_ff),
    .dead    (dead_ff),
    .restart (duty_ld),
    .pwm_h   (pwm_h),
    .pwm_l   (pwm_l)
  );

  // Step lookup, phases one-hot A=bit2
  function automatic hcc_gate_t step_of(input logic [2:0] code, input logic rev);
    hcc_gate_t g;
    g = '0;
    case (code)
      3'b001: g = '{hi: 3'b001, lo: 3'b010};
      3'b101: g = '{hi: 3'b100, lo: 3'b010};
      3'b100: g = '{hi: 3'b100, lo: 3'b001};
      3'b110: g = '{hi: 3'b010, lo: 3'b001};
      3'b010: g = '{hi: 3'b010, lo: 3'b100};
      3'b011: g = '{hi: 3'b001, lo: 3'b100};
      default: g = '0;
    endcase
    if (rev) begin
      g = '{hi: g.lo, lo: g.hi};
    end
    return g;
  endfunction

  // Event and fault detection
  assign hall_edge = (hall_s != hall_prev_ff);
  assign hall_bad  = (hall_s == 3'b000) || (hall_s == 3'b111);
  assign uv        = (adc_vbat < uvthr_ff);
  assign oclim     = (adc_ibus > oclim_ff);
  assign brake_on  = brake_s ^ ctrl_ff.brake_pol;
  assign fault     = hall_bad | uv | oclim | trip_s | brake_on | !ctrl_ff.enable;

  // Bus decode: address phase accepted this edge
  assign acc     = hsel && hready && htrans[1];
  assign duty_ld = wr_ff && (wa_ff == HCC_DUTY_OFS);

  // Status sources; set beats a same-cycle clear
  always_comb begin
    sts_set           = '0;
    sts_set[ST_HALL]  = hall_bad;
    sts_set[ST_UV]    = uv;
    sts_set[ST_OCLIM] = oclim;
    sts_set[ST_OCTRP] = trip_s;
    sts_set[ST_BRAKE] = (brake_s != brake_prev_ff);
    sts_set[ST_STEP]  = hall_edge;
  end

  // Register file next values
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_duty   = duty_ff;
    nxt_period = period_ff;
    nxt_dead   = dead_ff;
    nxt_uvthr  = uvthr_ff;
    nxt_oclim  = oclim_ff;
    nxt_mask   = mask_ff;
    nxt_sts    = sts_ff;
    if (wr_ff) begin
      if (wa_ff == HCC_CTRL_OFS) begin
        nxt_ctrl = hcc_ctrl_t'(hwdata[3:0]);
      end else if (wa_ff == HCC_DUTY_OFS) begin
        nxt_duty = hwdata[PW-1:0];
      end else if (wa_ff == HCC_PERIOD_OFS) begin
        nxt_period = hwdata[PW-1:0];
      end else if (wa_ff == HCC_DEAD_OFS) begin
        nxt_dead = hwdata[PW-1:0];
      end else if (wa_ff == HCC_UVTHR_OFS) begin
        nxt_uvthr = hwdata[AW-1:0];
      end else if (wa_ff == HCC_OCLIM_OFS) begin
        nxt_oclim = hwdata[AW-1:0];
      end else if (wa_ff == HCC_STS_OFS) begin
        nxt_sts = sts_ff & ~hwdata[ST_W-1:0];
      end else if (wa_ff == HCC_MASK_OFS) begin
        nxt_mask = hwdata[ST_W-1:0];
      end
    end
    nxt_sts = nxt_sts | sts_set;
  end

  // Bus phase tracking and read data
  always_comb begin
    nxt_wr = acc && hwrite;
    nxt_wa = acc ? haddr[7:0] : wa_ff;
    nxt_rd = rd_ff;
    if (acc && !hwrite) begin
      if (haddr[7:0] == HCC_CTRL_OFS) begin
        nxt_rd = {28'h0000000, ctrl_ff};
      end else if (haddr[7:0] == HCC_DUTY_OFS) begin
        nxt_rd = 32'(duty_ff);
      end else if (haddr[7:0] == HCC_PERIOD_OFS) begin
        nxt_rd = 32'(period_ff);
      end else if (haddr[7:0] == HCC_DEAD_OFS) begin
        nxt_rd = 32'(dead_ff);
      end else if (haddr[7:0] == HCC_UVTHR_OFS) begin
        nxt_rd = 32'(uvthr_ff);
      end else if (haddr[7:0] == HCC_OCLIM_OFS) begin
        nxt_rd = 32'(oclim_ff);
      end else if (haddr[7:0] == HCC_STS_OFS) begin
        nxt_rd = 32'(sts_ff);
      end else if (haddr[7:0] == HCC_MASK_OFS) begin
        nxt_rd = 32'(mask_ff);
      end else if (haddr[7:0] == HCC_SPEED_OFS) begin
        nxt_rd = 32'(speed_ff);
      end else if (haddr[7:0] == HCC_LIVE_OFS) begin
        nxt_rd = {21'h00000, fault, hall_s, brake_on, comm_ff}; // Full 32-bit word
      end else begin
        nxt_rd = 32'h00000000; // Unmapped reads zero
      end
    end
  end

  // Commutation and gate drive
  always_comb begin
    nxt_comm = hall_edge ? step_of(hall_s, ctrl_ff.reverse) : comm_ff;
    nxt_gate.hi = comm_ff.hi & {3{pwm_h}};
    nxt_gate.lo = comm_ff.lo;
    if (ctrl_ff.sync_rect) begin
      nxt_gate.lo = comm_ff.lo | (comm_ff.hi & {3{pwm_l}});
    end // otherwise complement stays off
    if (fault) begin
      nxt_gate = '0;
    end
  end

  // Speed window; counts settle once per window
  always_comb begin
    nxt_win   = win_ff + 1'b1;
    nxt_edges = edges_ff + {15'h0000, hall_edge};
    nxt_speed = speed_ff;
    if (win_ff == SW'(SPD_WIN - 1)) begin
      nxt_win   = '0;
      nxt_speed = nxt_edges;
      nxt_edges = '0;
    end
  end

  // All state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff       <= CTRL_RST;
      duty_ff       <= PW'(DUTY_RST);
      period_ff     <= PW'(PERIOD_RST);
      dead_ff       <= PW'(DEAD_RST);
      uvthr_ff      <= AW'(UVTHR_RST);
      oclim_ff      <= AW'(OCLIM_RST);
      sts_ff        <= '0;
      mask_ff       <= '0;
      hall_prev_ff  <= 3'h0;
      brake_prev_ff <= 1'b0;
      comm_ff       <= '0;
      gate_ff       <= '0;
      win_ff        <= '0;
      edges_ff      <= 16'h0000;
      speed_ff      <= 16'h0000;
      wr_ff         <= 1'b0;
      wa_ff         <= 8'h00;
      rd_ff         <= 32'h00000000;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      duty_ff       <= nxt_duty;
      period_ff     <= nxt_period;
      dead_ff       <= nxt_dead;
      uvthr_ff      <= nxt_uvthr;
      oclim_ff      <= nxt_oclim;
      sts_ff        <= nxt_sts;
      mask_ff       <= nxt_mask;
      hall_prev_ff  <= hall_s;
      brake_prev_ff <= brake_s;
      comm_ff       <= nxt_comm;
      gate_ff       <= nxt_gate;
      win_ff        <= nxt_win;
      edges_ff      <= nxt_edges;
      speed_ff      <= nxt_speed;
      wr_ff         <= nxt_wr;
      wa_ff         <= nxt_wa;
      rd_ff         <= nxt_rd;
    end
  end

  // Outputs; zero wait states, always OKAY
  assign gate      = gate_ff;
  assign hrdata    = rd_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(sts_ff & mask_ff);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fault_gates_off: assert property (fault |=> gate == '0)
    else $error("gates on during fault");
  // Skip the window that still reaches back into reset
  a_sync_two_stage: assert property (
    !$past(sys_rst, 2) |-> hall_s == $past(hall_pin, 2))
    else $error("hall sync latency wrong");
  a_bad_code_flag: assert property (hall_bad |=> sts_ff[ST_HALL])
    else $error("invalid hall code not flagged");
  a_step_on_edge: assert property (
    hall_edge && !hall_bad && !ctrl_ff.reverse
    |=> comm_ff.hi != '0 && (comm_ff.hi & comm_ff.lo) == '0)
    else $error("step not updated on hall edge");
  a_fwd_step_one: assert property (
    hall_edge && hall_s == 3'b001 && !ctrl_ff.reverse
    |=> comm_ff.hi == 3'b001 && comm_ff.lo == 3'b010)
    else $error("forward step 001 wrong");
  a_rev_step_one: assert property (
    hall_edge && hall_s == 3'b011 && ctrl_ff.reverse
    |=> comm_ff.hi == 3'b100 && comm_ff.lo == 3'b001)
    else $error("reverse step 011 wrong");
  // Gate lags control by one edge, so the mode must be off for two samples
  a_two_switch_only: assert property (
    !ctrl_ff.sync_rect && !$past(ctrl_ff.sync_rect)
    |-> $countones(gate.hi) <= 1 && $countones(gate.lo) <= 1
    && (gate.hi & gate.lo) == '0)
    else $error("more than two switches or shoot-through");
  a_no_complement: assert property (
    !$past(ctrl_ff.sync_rect) && !$past(fault)
    |-> gate.lo == $past(comm_ff.lo))
    else $error("complement driven in non-sync mode");
  a_duty_restart: assert property (duty_ld |=> u_pwm.cnt_ff == '0)
    else $error("duty load did not restart period");
  a_uv_detect: assert property (adc_vbat < uvthr_ff |=> sts_ff[ST_UV] ##0 gate == '0)
    else $error("undervoltage not caught");
  a_oc_trip_flag: assert property (trip_s |=> sts_ff[ST_OCTRP] && gate == '0)
    else $error("trip input not handled");
  a_brake_edge: assert property ($changed(brake_s) |=> sts_ff[ST_BRAKE])
    else $error("brake edge lost");

  c_forward_step: cover property (hall_edge && !hall_bad && !ctrl_ff.reverse ##1 gate.hi != '0);
  c_reverse_step: cover property (hall_edge && !hall_bad && ctrl_ff.reverse);
  c_sync_rect:    cover property (ctrl_ff.sync_rect && gate.lo != '0 && gate.hi == '0);
  c_irq_raised:   cover property ($rose(irq));
endmodule

// *** testbench/hcc_bridge_model.sv ***
// Purpose: Bridge and hall sensor stand-in for the commutation controller
// Assumes: Gates active high, {hi,lo} with bit 2 = phase A
// Notes:   Hall code comes from the bench; the model replays it on the pins
`timescale 1ns/1ps
module hcc_bridge_model
  import hcc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Bench code and bridge gates
  input  wire logic [2:0]         hall_code,
  input  wire hcc_pkg::hcc_gate_t gate,
  // Sensor pins and fault tally
  output logic      [2:0]         hall_pin,
  output int                      shoot_cnt
);
  // Three sensors, one line per phase
  assign hall_pin = hall_code;

  // Both switches of one leg, or two high sides, short the supply
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shoot_cnt <= 0;
    end else if ((|(gate.hi & gate.lo)) || ($countones(gate.hi) > 1)) begin
      shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule

// *** testbench/test_hall_commutation_control.sv ***
// Purpose: Self-checking bench for the hall commutation controller
// Assumes: Zero wait-state slave; speed window shortened to 200 cycles
// Notes:   Gate checks run with the high side at full duty unless stated
`timescale 1ns/1ps
`define CHK(act, exp) \
  begin \
    check_count++; \
    if ((act) !== (exp)) begin \
      err_count++; \
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, (act), (exp)); \
    end \
  end
module test_hall_commutation_control;
  import hcc_pkg::*;
  localparam int SPD = 200;
  // Forward table by code; reverse swaps the halves
  localparam logic [5:0] FWD [8] = '{6'o00, 6'o12, 6'o24, 6'o14, 6'o41, 6'o42, 6'o21, 6'o00};
  localparam logic [7:0] RA [8] = '{HCC_CTRL_OFS, HCC_DUTY_OFS, HCC_PERIOD_OFS,
    HCC_DEAD_OFS, HCC_UVTHR_OFS, HCC_OCLIM_OFS, HCC_MASK_OFS, 8'h30};
  localparam logic [31:0] RV [8] = '{32'(CTRL_RST), 32'(DUTY_RST), 32'(PERIOD_RST),
    32'(DEAD_RST), 32'(UVTHR_RST), 32'(OCLIM_RST), 32'h0, 32'h0};
  logic        clk, sys_rst, hsel, hwrite, brake_pin, oc_trip_pin;
  logic        hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, hall_code, hall_pin;
  logic [11:0] adc_vbat, adc_ibus;
  logic [31:0] haddr, hwdata, hrdata, rd;
  hcc_gate_t   gate;
  logic [5:0]  e;
  int          err_count, check_count, shoot_cnt, n_hi, n_lo, n_cp;

  hcc_top #(.SPD_WIN(SPD)) hcc_top_i (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hall_pin(hall_pin),
    .brake_pin(brake_pin), .oc_trip_pin(oc_trip_pin), .adc_vbat(adc_vbat),
    .adc_ibus(adc_ibus), .gate(gate), .irq(irq));

  hcc_bridge_model hcc_bridge_model_i (
    .clk(clk), .sys_rst(sys_rst), .hall_code(hall_code), .gate(gate),
    .hall_pin(hall_pin), .shoot_cnt(shoot_cnt));

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Verdict, reached from the main sequence or the watchdog
  task automatic summarize;
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One single AHB transfer; the master holds each phase until hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    `CHK(rd, x);
  endtask

  // Let synchronisers and gate registers catch up before looking
  task automatic settle;
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic pins(input logic [2:0] h, input logic b, input logic t,
                      input logic [11:0] v, input logic [11:0] i);
    @(posedge clk);
    hall_code   <= h;
    brake_pin   <= b;
    oc_trip_pin <= t;
    adc_vbat    <= v;
    adc_ibus    <= i;
    settle();
  endtask

  // Tally one PWM period of the A high, C low and A low gates
  task automatic count_pwm;
    n_hi = 0;
    n_lo = 0;
    n_cp = 0;
    repeat (40) @(posedge clk);
    repeat (32) begin
      @(posedge clk);
      #1;
      n_hi += (gate.hi[2] === 1'b1);
      n_lo += (gate.lo[0] === 1'b1);
      n_cp += (gate.lo[2] === 1'b1);
    end
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    {hsel, hwrite, brake_pin, oc_trip_pin} = 4'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    hall_code = 3'b100;
    adc_vbat = 12'hFFF;
    adc_ibus = 12'h000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped write ignored, gates off while disabled
    bus(1'b1, 8'h30, 32'hFFFFFFFF);
    for (int k = 0; k < 8; k++) begin
      chk_rd(RA[k], RV[k]);
    end
    `CHK(gate, 6'h00);
    // Full duty high side, short dead time, then walk every code both ways
    bus(1'b1, HCC_DEAD_OFS, 32'h2);
    bus(1'b1, HCC_PERIOD_OFS, 32'h20);
    bus(1'b1, HCC_DUTY_OFS, 32'h20);
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, HCC_CTRL_OFS, {30'h0, r[0], 1'b1});
      for (int h = 0; h < 8; h++) begin
        pins(h[2:0], 1'b0, 1'b0, 12'hFFF, 12'h000);
        e = (r == 0) ? FWD[h] : {FWD[h][2:0], FWD[h][5:3]};
        `CHK(gate, e);
      end
    end
    bus(1'b1, HCC_CTRL_OFS, 32'h1);
    bus(1'b0, HCC_STS_OFS, 32'h0);
    `CHK({rd[ST_STEP], rd[ST_HALL]}, 2'b11);
    // Protection thresholds at their boundaries
    pins(3'b100, 1'b0, 1'b0, 12'h7FF, 12'h000);
    `CHK(gate, 6'h00);
    pins(3'b100, 1'b0, 1'b0, 12'h800, 12'hC01);
    `CHK(gate, 6'h00);
    pins(3'b100, 1'b0, 1'b1, 12'h800, 12'hC00);
    `CHK(gate, 6'h00);
    pins(3'b100, 1'b1, 1'b0, 12'h800, 12'hC00);
    `CHK(gate, 6'h00);
    pins(3'b100, 1'b0, 1'b0, 12'h800, 12'hC00);
    `CHK(gate, FWD[4]);
    // Invalid-code bit still sticky from the walk, never cleared yet
    chk_rd(HCC_STS_OFS, 32'h3F);
    // Interrupt: clear, mask, raise, stick, clear; masked event stays quiet
    bus(1'b1, HCC_STS_OFS, 32'h3F);
    bus(1'b1, HCC_MASK_OFS, 32'h02);
    settle();
    `CHK(irq, 1'b0);
    pins(3'b100, 1'b0, 1'b0, 12'h100, 12'h000);
    pins(3'b100, 1'b0, 1'b0, 12'hFFF, 12'h000);
    `CHK(irq, 1'b1);
    bus(1'b1, HCC_STS_OFS, 32'h02);
    settle();
    `CHK(irq, 1'b0);
    pins(3'b100, 1'b1, 1'b0, 12'hFFF, 12'h000);
    pins(3'b100, 1'b0, 1'b0, 12'hFFF, 12'h000);
    `CHK(irq, 1'b0);
    bus(1'b1, HCC_MASK_OFS, 32'h10);
    settle();
    `CHK(irq, 1'b1);
    bus(1'b1, HCC_STS_OFS, 32'h3F);
    bus(1'b1, HCC_MASK_OFS, 32'h00);
    // Active-low brake
    bus(1'b1, HCC_CTRL_OFS, 32'h9);
    pins(3'b100, 1'b1, 1'b0, 12'hFFF, 12'h000);
    `CHK(gate, FWD[4]);
    pins(3'b100, 1'b0, 1'b0, 12'hFFF, 12'h000);
    `CHK(gate, 6'h00);
    bus(1'b1, HCC_CTRL_OFS, 32'h1);
    // Half duty: high side modulated, low side full on, complement idle, then driven with synchronous rectification
    bus(1'b1, HCC_DUTY_OFS, 32'h10);
    count_pwm();
    `CHK(n_hi, 14);
    `CHK(n_lo, 32);
    `CHK(n_cp, 0);
    bus(1'b1, HCC_CTRL_OFS, 32'h5);
    count_pwm();
    `CHK(n_hi, 14);
    `CHK(n_cp, 14);
    `CHK(n_lo, 32);
    bus(1'b1, HCC_CTRL_OFS, 32'h1);
    // Speed: a hall change every 10 cycles gives about 20 per window
    fork
      repeat (80) begin
        @(posedge clk);
        hall_code <= hall_code ^ 3'b010;
        repeat (9) @(posedge clk);
      end
      begin
        repeat (500) @(posedge clk);
        bus(1'b0, HCC_SPEED_OFS, 32'h0);
        `CHK((rd >= 32'd19) && (rd <= 32'd21), 1'b1);
      end
    join
    `CHK(shoot_cnt, 0);
    summarize();
  end
endmodule
